// ===== src/sacm_top.sv
// Purpose: Control, multiplexer decode and result format for a 10-bit SAR
// Assumes: Core handshake and timer overflows are on core_clk
// Notes:   Result bytes and window flag update in the completion cycle
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Upper nibbles of pair and channel read zero
// - Pair bit makes even/odd inputs differential
// - Differential results are two's complement
// - Address selects input 0-7 or temperature sensor
// - Gain field decodes to 1,2,4,8,16,0.5
// - Enable bit clear holds converter shut down
// - Track mode 0 tracks except while converting
// - Track mode 1 tracks per start mode
// - Completion flag sets and stays until cleared
// - Busy reads one during conversion, edge interrupts
// - Busy write starts only in software mode
// - Start mode picks software, timers or pin
// - Window flag sets when compare condition met
// - Right justify with sign or zero extension
// - Left justify, low six bits read zero
// - Conversion clock divided from system clock
// - Busy falling edge at conversion end sets completion flag
// - Window inside or outside by limit order
module sacm_top
	import sacm_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata,
	input  wire logic        timer2_ovf,
	input  wire logic        timer3_ovf,
	input  wire logic        external_convert_start,
	input  wire logic        conv_irq_en,
	output logic             conv_irq,
	input  wire logic [15:0] greater_limit,
	input  wire logic [15:0] less_limit,
	input  wire logic        core_done,
	input  wire logic [9:0]  core_data,
	output logic             adc_power,
	output logic             track_hold,
	output logic             conv_start,
	output logic             sar_tick,
	output logic      [2:0]  mux_pos_sel,
	output logic      [2:0]  mux_neg_sel,
	output logic             mux_neg_gnd,
	output logic             temp_sel,
	output logic             mux_diff,
	output logic      [2:0]  gain_sel
);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// Register file state
	logic [7:0]       pair_ff, nxt_pair;
	logic [7:0]       chan_ff, nxt_chan;
	logic [7:0]       cfg_ff, nxt_cfg;
	logic [7:0]       res_lo_ff, nxt_res_lo;
	logic [7:0]       res_hi_ff, nxt_res_hi;
	logic [7:0]       rdata_ff, nxt_rdata;
	logic             en_ff, nxt_en;
	logic             tm_ff, nxt_tm;
	logic             lj_ff, nxt_lj;
	logic             done_ff, nxt_done;
	logic             win_ff, nxt_win;
	sacm_start_mode_t mode_ff, nxt_mode;

	// Sequencer and latched channel state
	sacm_state_t      state_ff, nxt_state;
	logic [1:0]       trk_cnt_ff, nxt_trk_cnt;
	logic             start_ff, nxt_start;
	logic [2:0]       pos_ff, nxt_pos;
	logic [2:0]       neg_ff, nxt_neg;
	logic             gnd_ff, nxt_gnd;
	logic             temp_ff, nxt_temp;
	logic             diff_ff, nxt_diff;
	logic             lj_lat_ff, nxt_lj_lat;
	sacm_gain_t       gain_ff, nxt_gain;

	// External start pin synchroniser
	logic             pin_meta_ff;
	logic             pin_sync_ff;
	logic             pin_prev_ff;

	logic             wr_ctrl;
	logic             sw_start;
	logic             start_evt;
	logic             done_evt;
	logic             busy;
	logic [15:0]      word;
	logic [15:0]      wa, ga, la;
	logic             win_match;

	assign busy       = (state_ff != ST_IDLE);
	assign wr_ctrl    = sfr_wr && (sfr_addr == ADDR_CTRL);
	assign done_evt   = (state_ff == ST_CONV) && core_done;
	assign sfr_rdata  = rdata_ff;
	assign adc_power  = en_ff;
	assign conv_start = start_ff;
	assign conv_irq   = done_ff && conv_irq_en;
	assign mux_pos_sel = pos_ff;
	assign mux_neg_sel = neg_ff;
	assign mux_neg_gnd = gnd_ff;
	assign temp_sel    = temp_ff;
	assign mux_diff    = diff_ff;
	assign gain_sel    = gain_ff;

	sacm_sar_clkdiv u_clkdiv (
		.core_clk    (core_clk),
		.rst         (rst),
		.run         (en_ff && busy),
		.period_code (cfg_ff[CFG_CLK_H:CFG_CLK_L]),
		.sar_tick    (sar_tick)
	);

	// Pin passes two flops before use
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pin_meta_ff <= 1'b0;
			pin_sync_ff <= 1'b0;
			pin_prev_ff <= 1'b0;
		end else begin
			pin_meta_ff <= external_convert_start;
			pin_sync_ff <= pin_meta_ff;
			pin_prev_ff <= pin_sync_ff;
		end
	end

	// software start only in mode 00
	assign sw_start = wr_ctrl && sfr_wdata[CTRL_BUSY]
		&& (sfr_wdata[CTRL_SM_H:CTRL_SM_L] == SM_SOFTWARE);

	always_comb begin
		unique case (mode_ff)
			SM_SOFTWARE: start_evt = sw_start;
			SM_TIMER3:   start_evt = timer3_ovf;
			SM_PIN:      start_evt = pin_sync_ff && !pin_prev_ff;
			SM_TIMER2:   start_evt = timer2_ovf;
		endcase
	end

	always_comb begin
		if (!en_ff || state_ff == ST_CONV) begin
			track_hold = 1'b0;
		end else if (!tm_ff) begin
			track_hold = 1'b1;
		end else if (mode_ff == SM_PIN) begin
			track_hold = !pin_sync_ff;
		end else begin
			track_hold = (state_ff == ST_TRACK);
		end
	end

	// Sequencer next state
	always_comb begin
		nxt_state   = state_ff;
		nxt_trk_cnt = trk_cnt_ff;
		nxt_start   = 1'b0;
		unique case (state_ff)
			ST_IDLE: begin
				nxt_trk_cnt = 2'd0;
				if (en_ff && start_evt) begin
					if (tm_ff && mode_ff != SM_PIN) begin
						nxt_state = ST_TRACK;
					end else begin
						nxt_state = ST_CONV;
						nxt_start = 1'b1;
					end
				end
			end
			ST_TRACK: begin
				if (sar_tick) begin
					nxt_trk_cnt = trk_cnt_ff + 2'd1;
					if (trk_cnt_ff == TRACK_SAR_CLKS - 2'd1) begin
						nxt_state = ST_CONV;
						nxt_start = 1'b1;
					end
				end
			end
			ST_CONV: begin
				if (core_done) begin
					nxt_state = ST_IDLE;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
		if (!en_ff) begin
			nxt_state = ST_IDLE;
			nxt_start = 1'b0;
		end
	end

	always_comb begin
		nxt_pos    = pos_ff;
		nxt_neg    = neg_ff;
		nxt_gnd    = gnd_ff;
		nxt_temp   = temp_ff;
		nxt_diff   = diff_ff;
		nxt_gain   = gain_ff;
		nxt_lj_lat = lj_lat_ff;
		if (state_ff == ST_IDLE) begin
			nxt_lj_lat = nxt_lj; // A start write may set it
			nxt_temp   = chan_ff[CHAN_TEMP];
			nxt_diff   = !chan_ff[CHAN_TEMP] && pair_ff[chan_ff[2:1]];
			nxt_gnd    = !nxt_diff;
			// Odd address of a pair falls back to the pair
			nxt_pos    = nxt_diff ? {chan_ff[2:1], 1'b0} : chan_ff[2:0];
			nxt_neg    = {chan_ff[2:1], 1'b1};
			unique case (cfg_ff[CFG_GAIN_H:0])
				3'b000:         nxt_gain = GAIN_1;
				3'b001:         nxt_gain = GAIN_2;
				3'b010:         nxt_gain = GAIN_4;
				3'b011:         nxt_gain = GAIN_8;
				3'b100, 3'b101: nxt_gain = GAIN_16;
				3'b110, 3'b111: nxt_gain = GAIN_HALF;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_ff   <= ST_IDLE;
			trk_cnt_ff <= 2'd0;
			start_ff   <= 1'b0;
			pos_ff     <= 3'd0;
			neg_ff     <= 3'd1;
			gnd_ff     <= 1'b1;
			temp_ff    <= 1'b0;
			diff_ff    <= 1'b0;
			gain_ff    <= GAIN_1;
			lj_lat_ff  <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			trk_cnt_ff <= nxt_trk_cnt;
			start_ff   <= nxt_start;
			pos_ff     <= nxt_pos;
			neg_ff     <= nxt_neg;
			gnd_ff     <= nxt_gnd;
			temp_ff    <= nxt_temp;
			diff_ff    <= nxt_diff;
			gain_ff    <= nxt_gain;
			lj_lat_ff  <= nxt_lj_lat;
		end
	end

	// result word in its stored layout
	always_comb begin
		if (lj_lat_ff) begin
			word = {core_data, LJ_PAD};
		end else begin
			word = {{SIGN_W{diff_ff && core_data[DATA_W-1]}},
				core_data};
		end
	end

	always_comb begin
		wa   = word ^ (diff_ff ? SIGN_FLIP : 16'h0000);
		ga   = greater_limit ^ (diff_ff ? SIGN_FLIP : 16'h0000);
		la   = less_limit ^ (diff_ff ? SIGN_FLIP : 16'h0000);
		if (ga > la) begin
			win_match = (wa > ga) || (wa < la);
		end else begin
			win_match = (wa > ga) && (wa < la);
		end
	end

	// Register writes and hardware updates
	always_comb begin
		nxt_pair   = pair_ff;
		nxt_chan   = chan_ff;
		nxt_cfg    = cfg_ff;
		nxt_res_lo = res_lo_ff;
		nxt_res_hi = res_hi_ff;
		nxt_en     = en_ff;
		nxt_tm     = tm_ff;
		nxt_lj     = lj_ff;
		nxt_mode   = mode_ff;
		nxt_done   = done_ff;
		nxt_win    = win_ff;
		if (sfr_wr) begin
			unique case (sfr_addr)
				ADDR_PAIR:   nxt_pair = sfr_wdata & MASK_LOW_NIBBLE;
				ADDR_CHAN:   nxt_chan = sfr_wdata & MASK_LOW_NIBBLE;
				ADDR_CFG:    nxt_cfg = sfr_wdata & MASK_CFG;
				ADDR_RES_LO: nxt_res_lo = sfr_wdata;
				ADDR_RES_HI: nxt_res_hi = sfr_wdata;
				ADDR_CTRL: begin
					nxt_en   = sfr_wdata[CTRL_EN];
					nxt_tm   = sfr_wdata[CTRL_TM];
					nxt_done = sfr_wdata[CTRL_DONE];
					nxt_mode = sacm_start_mode_t'(
						sfr_wdata[CTRL_SM_H:CTRL_SM_L]);
					nxt_win  = sfr_wdata[CTRL_WIN];
					nxt_lj   = sfr_wdata[CTRL_LJ];
				end
				default: ;
			endcase
		end
		// both bytes load in one cycle
		if (done_evt) begin
			nxt_res_hi = word[15:8];
			nxt_res_lo = word[7:0];
			nxt_done = 1'b1;
			if (win_match) begin
				nxt_win = 1'b1;
			end
		end
	end

	// Read data registered one cycle after address
	always_comb begin
		unique case (sfr_addr)
			ADDR_PAIR:   nxt_rdata = pair_ff;
			ADDR_CHAN:   nxt_rdata = chan_ff;
			ADDR_CFG:    nxt_rdata = cfg_ff;
			ADDR_RES_LO: nxt_rdata = res_lo_ff;
			ADDR_RES_HI: nxt_rdata = res_hi_ff;
			ADDR_CTRL:   nxt_rdata = {en_ff, tm_ff, done_ff, busy,
				mode_ff, win_ff, lj_ff};
			default:     nxt_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pair_ff   <= RST_PAIR;
			chan_ff   <= RST_CHAN;
			cfg_ff    <= RST_CFG;
			res_lo_ff <= RST_RES;
			res_hi_ff <= RST_RES;
			en_ff     <= RST_CTRL[CTRL_EN];
			tm_ff     <= RST_CTRL[CTRL_TM];
			done_ff   <= RST_CTRL[CTRL_DONE];
			mode_ff   <= SM_SOFTWARE;
			win_ff    <= RST_CTRL[CTRL_WIN];
			lj_ff     <= RST_CTRL[CTRL_LJ];
			rdata_ff  <= 8'h00;
		end else begin
			pair_ff   <= nxt_pair;
			chan_ff   <= nxt_chan;
			cfg_ff    <= nxt_cfg;
			res_lo_ff <= nxt_res_lo;
			res_hi_ff <= nxt_res_hi;
			en_ff     <= nxt_en;
			tm_ff     <= nxt_tm;
			done_ff   <= nxt_done;
			mode_ff   <= nxt_mode;
			win_ff    <= nxt_win;
			lj_ff     <= nxt_lj;
			rdata_ff  <= nxt_rdata;
		end
	end

	a_pair_upper_zero: assert property (
		(sfr_addr == ADDR_PAIR || sfr_addr == ADDR_CHAN)
		|=> sfr_rdata[7:4] == 4'h0)
		else $error("upper nibble of pair or channel not zero");

	a_diff_decode: assert property (
		(state_ff == ST_IDLE && !chan_ff[CHAN_TEMP])
		|=> mux_diff == $past(pair_ff[chan_ff[2:1]]))
		else $error("differential decode wrong");

	a_temp_select: assert property (
		(state_ff == ST_IDLE) |=> temp_sel == $past(chan_ff[CHAN_TEMP]))
		else $error("temperature sensor select wrong");

	a_gain_half: assert property (
		(state_ff == ST_IDLE && cfg_ff[CFG_GAIN_H:1] == 2'b11)
		|=> gain_sel == GAIN_HALF)
		else $error("half gain not decoded");

	a_shutdown_idle: assert property (
		!en_ff |-> !track_hold ##1 state_ff == ST_IDLE)
		else $error("converter active while disabled");

	a_track_free: assert property (
		(en_ff && !tm_ff && state_ff != ST_CONV) |-> track_hold)
		else $error("not tracking in free track mode");

	a_track_three: assert property (
		(conv_start && $past(tm_ff) && $past(mode_ff) != SM_PIN)
		|-> $past(state_ff) == ST_TRACK
		&& $past(trk_cnt_ff) == TRACK_SAR_CLKS - 2'd1)
		else $error("timed tracking not three conversion ticks");

	a_done_sticky: assert property (
		done_evt |=> done_ff && !busy)
		else $error("completion flag not set at end");

	a_sw_start: assert property (
		(state_ff == ST_IDLE && en_ff && mode_ff == SM_SOFTWARE
		&& sw_start) |=> busy)
		else $error("software start not honoured");

	a_write0_ignored: assert property (
		(state_ff == ST_IDLE && wr_ctrl && !sfr_wdata[CTRL_BUSY]
		&& !(mode_ff != SM_SOFTWARE && start_evt)) |=> !busy)
		else $error("busy write of zero started conversion");

	a_sign_extend: assert property (
		(done_evt && !lj_lat_ff && diff_ff)
		|=> res_hi_ff[7:2] == {SIGN_W{res_hi_ff[1]}})
		else $error("sign extension wrong");

	a_left_pad: assert property (
		(done_evt && lj_lat_ff) |=> res_lo_ff[5:0] == LJ_PAD)
		else $error("left justified low bits not zero");

endmodule
`default_nettype wire

// ===== shared/sacm_pkg.sv
// Purpose: Shared constants and types for the converter control block
// Assumes: 8-bit special function register bus, 10-bit converter core
// Notes:   Register offsets are byte addresses on that bus
package sacm_pkg;

	// Register addresses
	localparam logic [7:0] ADDR_PAIR   = 8'hba;
	localparam logic [7:0] ADDR_CHAN   = 8'hbb;
	localparam logic [7:0] ADDR_CFG    = 8'hbc;
	localparam logic [7:0] ADDR_RES_LO = 8'hbe;
	localparam logic [7:0] ADDR_RES_HI = 8'hbf;
	localparam logic [7:0] ADDR_CTRL   = 8'he8;

	// Reset values
	localparam logic [7:0] RST_PAIR = 8'h00;
	localparam logic [7:0] RST_CHAN = 8'h00;
	localparam logic [7:0] RST_CFG  = 8'h60;
	localparam logic [7:0] RST_RES  = 8'h00;
	localparam logic [7:0] RST_CTRL = 8'h00;

	// Implemented bits of each register
	localparam logic [7:0] MASK_LOW_NIBBLE = 8'h0f;
	localparam logic [7:0] MASK_CFG        = 8'he7;

	// Control register bit positions
	localparam int CTRL_EN   = 7;
	localparam int CTRL_TM   = 6;
	localparam int CTRL_DONE = 5;
	localparam int CTRL_BUSY = 4;
	localparam int CTRL_SM_H = 3;
	localparam int CTRL_SM_L = 2;
	localparam int CTRL_WIN  = 1;
	localparam int CTRL_LJ   = 0;

	// Configuration register field positions
	localparam int CFG_CLK_H  = 7;
	localparam int CFG_CLK_L  = 5;
	localparam int CFG_GAIN_H = 2;

	// Channel address: bit 3 picks the temperature sensor
	localparam int CHAN_TEMP = 3;

	// Timing and format constants
	localparam logic [1:0]  TRACK_SAR_CLKS  = 2'd3;
	localparam logic [2:0]  SAR_DIV_MAX_LOG = 3'd4;
	localparam int          DATA_W          = 10;
	localparam int          SIGN_W          = 6;
	localparam logic [5:0]  LJ_PAD          = 6'h00;
	localparam logic [15:0] SIGN_FLIP       = 16'h8000;

	typedef enum logic [1:0] {
		SM_SOFTWARE = 2'b00,
		SM_TIMER3   = 2'b01,
		SM_PIN      = 2'b10,
		SM_TIMER2   = 2'b11
	} sacm_start_mode_t;

	typedef enum logic [2:0] {
		GAIN_1    = 3'b000,
		GAIN_2    = 3'b001,
		GAIN_4    = 3'b010,
		GAIN_8    = 3'b011,
		GAIN_16   = 3'b100,
		GAIN_HALF = 3'b101
	} sacm_gain_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_TRACK = 2'b01,
		ST_CONV  = 2'b10
	} sacm_state_t;

endpackage

// ===== src/sacm_sar_clkdiv.sv
// Purpose: Conversion clock tick derived from the system clock
// Assumes: Period code 0 runs at full rate, each step halves it
// Notes:   Codes at or above four all divide by sixteen
`timescale 1ns/1ps
`default_nettype none
module sacm_sar_clkdiv
	import sacm_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       run,
	input  wire logic [2:0] period_code,
	output logic            sar_tick
);

	logic [3:0] cnt_ff;
	logic [3:0] nxt_cnt;
	logic [3:0] limit;
	logic [2:0] log_div;

	// Divider count and tick on terminal count
	always_comb begin
		log_div  = (period_code >= SAR_DIV_MAX_LOG) ? SAR_DIV_MAX_LOG
			: period_code;
		limit    = 4'((5'h01 << log_div) - 5'h01);
		sar_tick = run && (cnt_ff == limit);
		if (!run || sar_tick) begin
			nxt_cnt = 4'h0;
		end else begin
			nxt_cnt = cnt_ff + 4'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cnt_ff <= 4'h0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

endmodule
`default_nettype wire

// ===== tb/sacm_core_model.sv
// Purpose: Behavioural analog core answering each conversion start
// Assumes: Conversion lasts a fixed count of conversion clock ticks
// Notes:   Data lines show the inverse of the last value between results
`timescale 1ns/1ps
`default_nettype none
module sacm_core_model #(
	parameter int TICKS = 12
) (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       conv_start,
	input  wire logic       sar_tick,
	input  wire logic [9:0] result,
	output logic            core_done,
	output logic      [9:0] core_data
);
	logic       busy_ff;
	int         cnt_ff;
	logic [9:0] last_ff;

	// Count ticks of one conversion, then hand back the result
	always_ff @(posedge core_clk) begin
		core_done <= 1'b0;
		core_data <= ~last_ff;
		if (rst) begin
			busy_ff <= 1'b0;
			cnt_ff  <= 0;
			last_ff <= 10'h000;
		end else if (conv_start) begin
			busy_ff <= 1'b1;
			cnt_ff  <= 0;
		end else if (busy_ff && sar_tick) begin
			cnt_ff <= cnt_ff + 1;
			if (cnt_ff == TICKS - 1) begin
				busy_ff   <= 1'b0;
				core_done <= 1'b1;
				core_data <= result;
				last_ff   <= result;
			end
		end
	end
endmodule
`default_nettype wire

// ===== tb/sar_adc_mux_control_bench.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Register bus writes are one-cycle strobes, reads lag one edge
// Notes:   Inputs change on the falling edge of the clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
	n_mismatch++; $display("unexpected at %0t: %h not %h", $time, a, e); \
	end end
module sar_adc_mux_control_bench
	import sacm_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  sfr_addr = 8'h00;
	logic        sfr_wr = 1'b0;
	logic [7:0]  sfr_wdata = 8'h00;
	logic [7:0]  sfr_rdata;
	logic        timer2_ovf = 1'b0;
	logic        timer3_ovf = 1'b0;
	logic        pin = 1'b0;
	logic        conv_irq_en = 1'b0;
	logic        conv_irq;
	logic [15:0] greater_limit = 16'hffff;
	logic [15:0] less_limit = 16'h0000;
	logic        core_done;
	logic [9:0]  core_data;
	logic [9:0]  result_in = 10'h000;
	logic        adc_power, track_hold, conv_start, sar_tick;
	logic [2:0]  mux_pos_sel, mux_neg_sel, gain_sel;
	logic        mux_neg_gnd, temp_sel, mux_diff;
	int          n_mismatch = 0;
	int          check_count = 0;

	sacm_top sacm_top_i (.core_clk(core_clk), .rst(rst),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .timer2_ovf(timer2_ovf),
		.timer3_ovf(timer3_ovf), .external_convert_start(pin),
		.conv_irq_en(conv_irq_en), .conv_irq(conv_irq),
		.greater_limit(greater_limit), .less_limit(less_limit),
		.core_done(core_done), .core_data(core_data),
		.adc_power(adc_power), .track_hold(track_hold),
		.conv_start(conv_start), .sar_tick(sar_tick),
		.mux_pos_sel(mux_pos_sel), .mux_neg_sel(mux_neg_sel),
		.mux_neg_gnd(mux_neg_gnd), .temp_sel(temp_sel),
		.mux_diff(mux_diff), .gain_sel(gain_sel));
	sacm_core_model #(.TICKS(12)) sacm_core_model_i (.core_clk(core_clk),
		.rst(rst), .conv_start(conv_start), .sar_tick(sar_tick),
		.result(result_in), .core_done(core_done), .core_data(core_data));

	// System clock, 20 ns period
	always #10 core_clk = ~core_clk;

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		sfr_addr  = a;
		sfr_wdata = d;
		sfr_wr    = 1'b1;
		@(negedge core_clk);
		sfr_wr = 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(negedge core_clk);
		sfr_addr = a;
		@(negedge core_clk);
		`CHK(sfr_rdata, e)
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic wait_start(input int lim, output bit f, output int n);
		// Start may already stand as the write task returns
		f = (conv_start === 1'b1);
		for (n = 1; n <= lim && !f; n++) begin
			@(negedge core_clk);
			f = (conv_start === 1'b1);
		end
	endtask

	task automatic wait_done();
		int i;
		for (i = 0; i < 400 && core_done !== 1'b1; i++) @(negedge core_clk);
		`CHK(core_done, 1'b1)
		idle(2);
	endtask

	task automatic conv(input logic [7:0] c, input logic [9:0] d);
		bit f;
		int n;
		result_in = d;
		wr(ADDR_CTRL, c);
		wait_start(20, f, n);
		`CHK(f, 1'b1)
		wait_done();
	endtask

	task automatic pulse(input bit t3);
		@(negedge core_clk);
		if (t3) timer3_ovf = 1'b1;
		else timer2_ovf = 1'b1;
		@(negedge core_clk);
		timer3_ovf = 1'b0;
		timer2_ovf = 1'b0;
	endtask

	task automatic t_reset();
		rchk(ADDR_PAIR, RST_PAIR);
		rchk(ADDR_CHAN, RST_CHAN);
		rchk(ADDR_CFG, RST_CFG);
		rchk(ADDR_RES_LO, RST_RES);
		rchk(ADDR_RES_HI, RST_RES);
		rchk(ADDR_CTRL, RST_CTRL);
		`CHK(adc_power, 1'b0)
		wr(8'h00, 8'h5a);
		rchk(8'h00, 8'h00);
		wr(ADDR_PAIR, 8'hff);
		rchk(ADDR_PAIR, 8'h0f);
		wr(ADDR_CHAN, 8'hff);
		rchk(ADDR_CHAN, 8'h0f);
		wr(ADDR_CFG, 8'hff);
		rchk(ADDR_CFG, 8'he7);
		$display("test reset and masks done");
	endtask

	task automatic t_mux();
		logic [2:0] g;
		wr(ADDR_CTRL, 8'h80);
		wr(ADDR_PAIR, 8'h00);
		idle(2);
		`CHK(adc_power, 1'b1)
		`CHK(track_hold, 1'b1)
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_CHAN, 8'(i));
			idle(2);
			`CHK({mux_pos_sel, mux_neg_gnd, mux_diff}, {3'(i), 2'b10})
		end
		wr(ADDR_CHAN, 8'h0c);
		idle(2);
		`CHK(temp_sel, 1'b1)
		wr(ADDR_PAIR, 8'h0f);
		wr(ADDR_CHAN, 8'h02);
		idle(2);
		`CHK({mux_pos_sel, mux_neg_sel, mux_neg_gnd}, 7'b0100110)
		`CHK({mux_diff, temp_sel}, 2'b10)
		for (int i = 0; i < 8; i++) begin
			g = 3'(i);
			wr(ADDR_CFG, {5'h00, g});
			idle(2);
			`CHK(gain_sel, g[2] ? {2'b10, g[1]} : g)
		end
		wr(ADDR_PAIR, 8'h00);
		wr(ADDR_CHAN, 8'h00);
		$display("test mux and gain done");
	endtask

	task automatic t_soft();
		bit f;
		int n;
		conv_irq_en = 1'b1;
		result_in = 10'h2a5;
		wr(ADDR_CTRL, 8'h90);
		wait_start(20, f, n);
		`CHK(f, 1'b1)
		`CHK(track_hold, 1'b0)
		rchk(ADDR_CTRL, 8'h90);
		wait_done();
		rchk(ADDR_RES_HI, 8'h02);
		rchk(ADDR_RES_LO, 8'ha5);
		idle(5);
		rchk(ADDR_CTRL, 8'ha0);
		`CHK(conv_irq, 1'b1)
		conv_irq_en = 1'b0;
		idle(1);
		`CHK(conv_irq, 1'b0)
		wr(ADDR_CTRL, 8'h80);
		wait_start(20, f, n);
		`CHK(f, 1'b0)
		wr(ADDR_CTRL, 8'h94);
		wait_start(20, f, n);
		`CHK(f, 1'b0)
		// Back to software start mode for later tests
		wr(ADDR_CTRL, 8'h80);
		$display("test software start done");
	endtask

	task automatic t_format();
		logic [9:0]  d;
		logic [15:0] w;
		d = 10'h3fe;
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_PAIR, {7'h00, k[1]});
			conv({7'h48, k[0]}, d);
			w = k[0] ? {d, 6'h00} : {{6{d[9] & k[1]}}, d};
			rchk(ADDR_RES_HI, w[15:8]);
			rchk(ADDR_RES_LO, w[7:0]);
		end
		wr(ADDR_PAIR, 8'h00);
		$display("test result format done");
	endtask

	task automatic t_window();
		logic [15:0] gt [4] = '{16'h0100, 16'h0100, 16'h0100, 16'h0200};
		logic [15:0] lt [4] = '{16'h0200, 16'h0200, 16'h0200, 16'h0100};
		logic [9:0]  dv [4] = '{10'h150, 10'h250, 10'h200, 10'h250};
		logic        ex [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
		logic [3:0]  tk;
		for (int k = 0; k < 4; k++) begin
			greater_limit = gt[k];
			less_limit = lt[k];
			conv(8'h90, dv[k]);
			rchk(ADDR_CTRL, {6'h28, ex[k], 1'b0});
		end
		greater_limit = 16'hffff;
		less_limit = 16'h0000;
		// Period code 1 halves the conversion clock
		wr(ADDR_CFG, 8'h27);
		wr(ADDR_CTRL, 8'h90);
		for (int i = 0; i < 4; i++) begin
			@(negedge core_clk);
			tk[3 - i] = sar_tick;
		end
		`CHK(tk, 4'b1010)
		wait_done();
		$display("test window compare done");
	endtask

	task automatic t_timers();
		bit f;
		int n;
		for (int k = 0; k < 2; k++) begin
			result_in = 10'h111;
			wr(ADDR_CTRL, k ? 8'hcc : 8'hc4);
			pulse(k[0]);
			wait_start(20, f, n);
			`CHK(f, 1'b0)
			pulse(!k[0]);
			wait_start(100, f, n);
			`CHK(f, 1'b1)
			`CHK(n >= 3, 1'b1)
			wait_done();
		end
		wr(ADDR_CTRL, 8'hc8);
		idle(4);
		`CHK(track_hold, 1'b1)
		pin = 1'b1;
		wait_start(20, f, n);
		`CHK(f, 1'b1)
		`CHK(track_hold, 1'b0)
		wait_done();
		pin = 1'b0;
		wr(ADDR_CTRL, 8'h00);
		idle(2);
		`CHK(adc_power, 1'b0)
		$display("test start sources done");
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (12) @(negedge core_clk);
		rst = 1'b0;
		t_reset();
		t_mux();
		t_soft();
		t_format();
		t_window();
		t_timers();
		final_report();
	end

	// Watchdog against a hung wait
	initial begin
		#(20 * 20000);
		n_mismatch++;
		final_report();
	end
endmodule
`default_nettype wire
